// ---- rtl/wrc_top.sv ----
/*
 Warm reset control: drives the open-drain warm reset pin, filters
 external requests on it and keeps the reset cause flags.
 Assumes the pin is pulled up on the board, the power-on reset pin
 and warm reset pin are asynchronous, and the sources are on clk_in.
*/
`timescale 1ns/1ps

module wrc_top
    import wrc_pkg::*;
#(
    parameter int OSC_DIV = OSC_DIV_DEF,
    parameter int PERIPHERAL_CLOCK_DIV = PERIPHERAL_CLOCK_DIV_DEF,
    parameter int FILT_CYCLES = FILT_CYC,
    parameter int POR_CYCLES = POR_OSC_CYC,
    parameter int SRC_CYCLES = SRC_PERIPHERAL_CLOCK_CYC
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Power-on reset pin, active low
    input wire logic power_on_reset_n_in,
    // Warm reset open-drain pin
    input wire logic warm_reset_n_in,
    output logic warm_reset_n_out,
    output logic warm_reset_oe_out,
    // Internal reset sources
    input wire wrc_src_t src_in,
    // Status clear strobes, one bit per flag
    input wire logic [15:0] esr_clear_in,
    input wire logic [15:0] gsr_clear_in,
    // Status and internal reset
    output logic [15:0] esr_out,
    output logic [15:0] gsr_out,
    output logic sys_reset_n_out
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    // Synchronisers for the two asynchronous pins
    logic por_s1_r;
    logic por_s2_r;
    logic pin_s1_r;
    logic pin_s2_r;
    // Slow rate dividers and their tick pulses
    logic [7:0] osc_div_r;
    logic [7:0] peripheral_clock_div_r;
    logic osc_tick_r;
    logic peripheral_clock_tick_r;
    // Glitch filter counter and qualified request pulse
    logic [7:0] filt_cnt_r;
    logic ext_req_r;
    // Sequencer
    wrc_state_t state_r;
    wrc_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic drive_r;
    // Status
    logic [15:0] esr_r;
    logic [15:0] gsr_r;
    logic [15:0] esr_set;
    logic [15:0] gsr_set;
    logic src_any;

    // Pin is open drain: the level driven is always low
    assign warm_reset_n_out = 1'b0;
    assign warm_reset_oe_out = drive_r;
    assign esr_out = esr_r;
    assign gsr_out = gsr_r;

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers

    // Two flops per pin; only the second stage is read
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            por_s1_r <= 1'b0;
            por_s2_r <= 1'b0;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end
        else
        begin
            por_s1_r <= power_on_reset_n_in;
            por_s2_r <= por_s1_r;
            pin_s1_r <= warm_reset_n_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator and peripheral clock enables

    // Oscillator rate tick
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            osc_div_r <= 8'h00;
            osc_tick_r <= 1'b0;
        end
        else if (osc_div_r == 8'(OSC_DIV - 1))
        begin
            osc_div_r <= 8'h00;
            osc_tick_r <= 1'b1;
        end
        else
        begin
            osc_div_r <= osc_div_r + 8'h01;
            osc_tick_r <= 1'b0;
        end
    end

    // Peripheral clock rate tick
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            peripheral_clock_div_r <= 8'h00;
            peripheral_clock_tick_r <= 1'b0;
        end
        else if (peripheral_clock_div_r == 8'(PERIPHERAL_CLOCK_DIV - 1))
        begin
            peripheral_clock_div_r <= 8'h00;
            peripheral_clock_tick_r <= 1'b1;
        end
        else
        begin
            peripheral_clock_div_r <= peripheral_clock_div_r + 8'h01;
            peripheral_clock_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Glitch filter on the warm reset pin

    // Counts consecutive low samples; any high restarts the count.
    // Held in reset while we drive, since our own pull-down would
    // otherwise read back as an external request.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            filt_cnt_r <= 8'h00;
            ext_req_r <= 1'b0;
        end
        else if (drive_r || pin_s2_r)
        begin
            filt_cnt_r <= 8'h00;
            ext_req_r <= 1'b0;
        end
        else if (filt_cnt_r == 8'(FILT_CYCLES - 1))
        begin
            // Qualified: pulses every other cycle while the count holds, until our own drive resets the filter
            filt_cnt_r <= filt_cnt_r;
            ext_req_r <= ~ext_req_r & (filt_cnt_r != 8'hFF);
        end
        else
        begin
            filt_cnt_r <= filt_cnt_r + 8'h01;
            ext_req_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset sequencer

    // Any internal source or a qualified external request
    assign src_any = (|src_in) | ext_req_r;

    // Next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            WRC_POR:
            begin
                // Leave only once the oscillator stretch ran out
                if (por_s2_r && cnt_r == '0 && osc_tick_r)
                    state_nxt = WRC_HOLD;
            end
            WRC_HOLD:
            begin
                if (!por_s2_r)
                    state_nxt = WRC_POR;
                else if (!src_any && cnt_r == '0)
                    state_nxt = WRC_RUN;
            end
            WRC_RUN:
            begin
                if (!por_s2_r)
                    state_nxt = WRC_POR;
                else if (src_any)
                    state_nxt = WRC_HOLD;
            end
            default:
                state_nxt = WRC_POR;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            state_r <= WRC_POR;
        else
            state_r <= state_nxt;
    end

    // Stretch counter: reloads while a cause stands, counts down on
    // the tick of the rate that applies to the current phase.
    // Entering hold from power-on also loads the short stretch.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            cnt_r <= CNT_W'(POR_CYCLES);
        else if (!por_s2_r)
            cnt_r <= CNT_W'(POR_CYCLES);
        else if (state_r == WRC_POR)
        begin
            if (state_nxt == WRC_HOLD)
                cnt_r <= CNT_W'(SRC_CYCLES);
            else if (osc_tick_r && cnt_r != '0)
                cnt_r <= cnt_r - 1'b1;
        end
        else if (src_any)
            cnt_r <= CNT_W'(SRC_CYCLES);
        else if (peripheral_clock_tick_r && cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    // Pin drive and internal reset follow the sequencer
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            drive_r <= 1'b1;
            sys_reset_n_out <= 1'b0;
        end
        else
        begin
            drive_r <= (state_nxt != WRC_RUN);
            sys_reset_n_out <= (state_nxt == WRC_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reset cause flags

    // Set terms per cause
    always_comb
    begin
        esr_set = 16'h0000;
        gsr_set = 16'h0000;
        esr_set[ESR_POR_BIT] = ~por_s2_r;
        esr_set[ESR_WDOG_BIT] = src_in.watchdog | src_in.debug_reset;
        esr_set[ESR_STC_BIT] = src_in.stc_cpu_reset;
        esr_set[ESR_SW_BIT] = src_in.sw_reset;
        esr_set[ESR_EXT_BIT] = ext_req_r;
        gsr_set[GSR_OSC_BIT] = src_in.osc_fail;
        gsr_set[GSR_SLIP_LO_BIT] = src_in.pll_slip;
        gsr_set[GSR_SLIP_HI_BIT] = src_in.pll_slip;
    end

    // Flags are cleared only by software or the block reset, never by
    // the warm reset they record; a set in the clear cycle wins.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            esr_r <= ESR_RST;
            gsr_r <= GSR_RST;
        end
        else
        begin
            esr_r <= (esr_r & ~esr_clear_in) | esr_set;
            gsr_r <= (gsr_r & ~gsr_clear_in) | gsr_set;
        end
    end

endmodule : wrc_top

// ---- rtl/wrc_pkg.sv ----
/*
 Warm reset control package: timing counts, status bit positions,
 carrier struct and sequencer states.
 Assumes a 100 MHz system clock.
*/
package wrc_pkg;
    // System clock period
    localparam int CLK_PERIOD_NS = 10;
    // Glitch filter window on the warm reset pin
    localparam int FILT_MIN_NS = 475;
    localparam int FILT_MAX_NS = 2000;
    // Least time rounds up to whole cycles
    localparam int FILT_CYC = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Stretch after power-on release, in oscillator cycles
    localparam int POR_OSC_CYC = 2256;
    // Stretch for every other source, in peripheral clock cycles
    localparam int SRC_PERIPHERAL_CLOCK_CYC = 32;
    // Width of the stretch counter
    localparam int CNT_W = 12;
    // Default clock dividers for the slower rates
    localparam int OSC_DIV_DEF = 5;
    localparam int PERIPHERAL_CLOCK_DIV_DEF = 2;
    // Exception status bit positions
    localparam int ESR_POR_BIT = 15;
    localparam int ESR_WDOG_BIT = 13;
    localparam int ESR_STC_BIT = 5;
    localparam int ESR_SW_BIT = 4;
    localparam int ESR_EXT_BIT = 3;
    // Global status bit positions
    localparam int GSR_OSC_BIT = 0;
    localparam int GSR_SLIP_LO_BIT = 8;
    localparam int GSR_SLIP_HI_BIT = 9;
    // Status reset values
    localparam logic [15:0] ESR_RST = 16'h0000;
    localparam logic [15:0] GSR_RST = 16'h0000;

    // Internal reset sources, all active high levels
    typedef struct packed {
        logic osc_fail;
        logic pll_slip;
        logic watchdog;
        logic debug_reset;
        logic stc_cpu_reset;
        logic sw_reset;
    } wrc_src_t;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        WRC_POR = 3'b001,
        WRC_HOLD = 3'b010,
        WRC_RUN = 3'b100
    } wrc_state_t;
endpackage : wrc_pkg

// ---- verif/wrc_ext_model.sv ----
/* Board side of the warm reset line: pull-up plus an external requester.
 Assumes oe_in high means the device pulls the line low. */
`timescale 1ns/1ps
module wrc_ext_model
(
    // Device drive and external request
    input wire logic oe_in,
    input wire logic ext_low_in,
    // Resolved line level
    output logic pin_out
);
    // Pull-up wins only when nobody pulls low
    assign pin_out = !(oe_in || ext_low_in);
endmodule : wrc_ext_model

// ---- verif/wrc_top_props.sv ----
/* Checker for warm reset control, bound to the top ports.
 Assumes sim stretch counts of at least 8 clocks. */
`timescale 1ns/1ps
module wrc_top_props
    import wrc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic power_on_reset_n_in,
    input wire logic warm_reset_n_in,
    input wire logic warm_reset_n_out,
    input wire logic warm_reset_oe_out,
    input wire wrc_src_t src_in,
    input wire logic [15:0] esr_clear_in,
    input wire logic [15:0] gsr_clear_in,
    input wire logic [15:0] esr_out,
    input wire logic [15:0] gsr_out,
    input wire logic sys_reset_n_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // Any internal source active
    wire logic any_src;
    assign any_src = |src_in;
    ////////////////////////////////////////////////////////////////
    property p_low; warm_reset_n_out == 1'b0; endproperty
    a_low: assert property (p_low) else $error("pin driven high");
    property p_rise; $rose(any_src) |-> ##2 warm_reset_oe_out; endproperty
    a_rise: assert property (p_rise) else $error("no reset on source");
    property p_hold; $fell(any_src) |-> ##1 warm_reset_oe_out [*6]; endproperty
    a_hold: assert property (p_hold) else $error("stretch short");
    property p_rel; $fell(warm_reset_oe_out) |-> !$past(any_src) && !$past(any_src, 2);
    endproperty
    a_rel: assert property (p_rel) else $error("early release");
    property p_sys; warm_reset_oe_out |-> !sys_reset_n_out; endproperty
    a_sys: assert property (p_sys) else $error("core out of reset");
    property p_sw; src_in.sw_reset |=> esr_out[ESR_SW_BIT]; endproperty
    a_sw: assert property (p_sw) else $error("sw flag");
    property p_slip; src_in.pll_slip |=> gsr_out[9:8] == 2'h3; endproperty
    a_slip: assert property (p_slip) else $error("slip flag");
    property p_stk; 1'b1 |=> ($past(esr_out & ~esr_clear_in) & ~esr_out) == 16'h0000;
    endproperty
    a_stk: assert property (p_stk) else $error("flag lost");
    property p_por; !power_on_reset_n_in |-> ##3 esr_out[ESR_POR_BIT]; endproperty
    a_por: assert property (p_por) else $error("power-up flag");
    property p_ext; $rose(esr_out[ESR_EXT_BIT]) |-> warm_reset_oe_out; endproperty
    a_ext: assert property (p_ext) else $error("external no reset");
    // Main scenarios reached
    c_por: cover property ($rose(power_on_reset_n_in));
    c_oe: cover property ($rose(warm_reset_oe_out));
    c_ext: cover property ($rose(esr_out[ESR_EXT_BIT]));
endmodule : wrc_top_props

// ---- verif/wrc_top_tb.sv ----
/* Bench: power-up, each source, and pin filter scenarios.
 Assumes short sim stretch counts set below. */
`timescale 1ns/1ps
module wrc_top_tb;
    import wrc_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic por_n = 1'b0;
    logic ext_low = 1'b0;
    wrc_src_t src = '0;
    logic [15:0] clr = 16'h0000;
    logic pin, d_out, oe, sys_n;
    logic [15:0] esr, gsr;
    int n_fail = 0;
    int check_count = 0;
    always #5 clk_in = ~clk_in;
    // Short stretch counts so the run stays brief
    localparam int SIM_POR = 8;
    localparam int SIM_SRC = 4;
    wrc_top #(.POR_CYCLES(SIM_POR), .SRC_CYCLES(SIM_SRC)) u_dut (.clk_in(clk_in),
        .arst_n_in(arst_n_in), .power_on_reset_n_in(por_n), .warm_reset_n_in(pin),
        .warm_reset_n_out(d_out), .warm_reset_oe_out(oe), .src_in(src),
        .esr_clear_in(clr), .gsr_clear_in(clr), .esr_out(esr), .gsr_out(gsr),
        .sys_reset_n_out(sys_n));
    wrc_ext_model u_ext (.oe_in(oe), .ext_low_in(ext_low), .pin_out(pin));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait for release, counting clocks
    task automatic wait_rel(output int n);
        n = 0;
        while (oe !== 1'b0 && n < 300)
        begin
            @(negedge clk_in);
            n++;
        end
        // A release that never comes counts as a mismatch
        chk("release", 32'h0, 32'(oe));
    endtask : wait_rel
    // Clear all flags, then confirm they are gone
    task automatic clear_all;
        @(posedge clk_in) clr <= 16'hFFFF;
        @(posedge clk_in) clr <= 16'h0000;
        @(negedge clk_in);
        chk("cleared", 32'h0, {gsr, esr});
    endtask : clear_all
    // Power-on pin low, then released; also usable in mid-run
    task automatic t_por;
        int n;
        @(posedge clk_in) por_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        chk("por_drive", 32'h1, 32'(oe));
        @(posedge clk_in) por_n <= 1'b1;
        wait_rel(n);
        chk("por_hold", 32'h1, 32'(n >= SIM_POR * OSC_DIV_DEF));
        chk("por_flag", 32'h8000, {gsr, esr});
        chk("sys_run", 32'h1, 32'(sys_n));
        clear_all();
    endtask : t_por
    task automatic t_src(input int i, input logic [31:0] e);
        int n;
        @(posedge clk_in) src <= wrc_src_t'(6'h01 << i);
        @(posedge clk_in) src <= '0;
        @(posedge clk_in);
        @(negedge clk_in);
        chk("oe_rise", 32'h1, 32'(oe));
        wait_rel(n);
        // Pin went low two edges before this wait began, so two cycles more
        chk("src_hold", 32'h1, 32'(n + 2 >= SIM_SRC * PERIPHERAL_CLOCK_DIV_DEF));
        chk("src_flag", e, {gsr, esr});
        clear_all();
    endtask : t_src
    // Low pulse of w clocks from the outside
    task automatic t_ext(input int w, input logic [31:0] e);
        int n;
        logic seen;
        seen = 1'b0;
        @(posedge clk_in) ext_low <= 1'b1;
        // Watch for our own reset while the outside holds the line
        repeat (w)
        begin
            @(negedge clk_in);
            seen = seen | oe;
        end
        @(posedge clk_in) ext_low <= 1'b0;
        chk("ext_rst", 32'(e != 32'h0), 32'(seen));
        repeat (4) @(negedge clk_in);
        wait_rel(n);
        chk("ext_flag", e, {gsr, esr});
        clear_all();
    endtask : t_ext
    function automatic logic [31:0] exp_flag(input int i);
        case (i)
            0: return 32'h1 << ESR_SW_BIT;
            1: return 32'h1 << ESR_STC_BIT;
            2, 3: return 32'h1 << ESR_WDOG_BIT;
            4: return 32'h3 << (GSR_SLIP_LO_BIT + 16);
            default: return 32'h1 << (GSR_OSC_BIT + 16);
        endcase
    endfunction : exp_flag
    task automatic end_of_test;
        $display("checks %0d fails %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        t_por();
        for (int i = 0; i < 6; i++)
            t_src(i, exp_flag(i));
        t_por();
        t_ext(44, 32'h0);
        t_ext(210, 32'h1 << ESR_EXT_BIT);
        end_of_test();
    end
    // Hang guard
    initial
    begin
        #50000;
        n_fail++;
        end_of_test();
    end
endmodule : wrc_top_tb
bind wrc_top wrc_top_props u_props (.*);
